// ### src/drs_ctrl.sv
`timescale 1ns/1ns
// Overview of operation
// R1: refresh is cs ras cas low, we high
// R2: refresh only with all banks precharged
// R3: dram counts rows, banks idle after refresh
// R4: only deselect during tRFC after refresh
// R5: refresh every tREFI, postpone at most eight
// R6: pull in at most eight, no further credit
// R7: clear postponed refreshes before self-refresh
// R8: self-refresh entry is refresh with cke low
// R9: odt low ODTL plus half clock first
// R10: cke held low keeps self-refresh
// R11: dram stops dll, resets on exit
// R12: writes wait 512 clocks if vref floated
// R13: dram refreshes itself within tCKE
// R14: stay in self-refresh at least tCKE
// R15: wait tXS, tXSDLL for dll commands
// R16: deselect through tXS, refresh before re-entry
// R17: odt off throughout tXSDLL after exit
// R18: power-down only when nothing busy
// R19: dram picks precharge or active power-down
// R20: deselect around cke fall for tCPDED
// R21: tXP always, tXPDLL after slow exit
// R22: power-down bounded, tCKE low and high
// R23: signed refresh debt clamped at eight
module drs_ctrl #(
   parameter int CK_HALF = drs_pkg::CK_HALF
) (
   input wire logic clk,
   input wire logic resetn,
   drs_link_if.ctrl link,
   input wire logic ref_defer,
   input wire logic pull_in,
   input wire logic sr_req,
   input wire logic pd_req,
   input wire logic busy,
   input wire logic banks_idle,
   input wire logic mr0_a12,
   input wire logic vref_float,
   input wire logic odt_req,
   input wire logic mem_rst_req,
   output logic ref_urgent,
   output logic cmd_ok,
   output logic dll_ok,
   output logic wr_ok,
   output drs_pkg::drs_cstate_t state,
   output logic signed [4:0] ref_debt
);

   generate
      if (CK_HALF < 1 || CK_HALF > 15) begin : g_chk
         $error("drs_ctrl needs CK_HALF from 1 to 15");
      end
   endgenerate

   localparam logic signed [4:0] DMAX = 5'(drs_pkg::DEBT_LIMIT);
   localparam logic signed [4:0] DMIN = -DMAX;
   localparam int TW = drs_pkg::TW;

   // ----------------------------------------------------------------
   // link clock divider
   // ----------------------------------------------------------------
   logic [3:0] ck_cnt;
   logic ck_q;

   wire ck_flip = (ck_cnt == 4'(CK_HALF - 1));
   // pins change on the falling ck edge, so the dram sees them settled at the rise
   wire tick = ck_flip & ck_q;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ck_cnt <= '0;
         ck_q <= 1'b0;
      end else if (ck_flip) begin
         ck_cnt <= '0;
         ck_q <= ~ck_q;
      end else begin
         ck_cnt <= ck_cnt + 4'h1;
      end
   end

   assign link.ck = ck_q;

   // ----------------------------------------------------------------
   // timers, stepped once per link clock
   // ----------------------------------------------------------------
   logic main_ld;
   logic [TW-1:0] main_val;
   logic main_done;
   logic dll_ld;
   logic [TW-1:0] dll_val;
   logic dll_done;
   logic refi_ld;
   logic refi_done;
   logic vref_ld;
   logic vref_done;

   drs_timer #(.W(TW)) u_main (
      .clk(clk),
      .resetn(resetn),
      .load(main_ld),
      .value(main_val),
      .step(tick),
      .done(main_done)
   );

   drs_timer #(.W(TW)) u_dll (
      .clk(clk),
      .resetn(resetn),
      .load(dll_ld),
      .value(dll_val),
      .step(tick),
      .done(dll_done)
   );

   // R5: one tREFI interval per debt step
   drs_timer #(.W(TW)) u_refi (
      .clk(clk),
      .resetn(resetn),
      .load(refi_ld),
      .value(TW'(drs_pkg::TREFI_NCK - 1)),
      .step(tick),
      .done(refi_done)
   );

   // R12: write hold-off after a floated reference
   drs_timer #(.W(TW)) u_vref (
      .clk(clk),
      .resetn(resetn),
      .load(vref_ld),
      .value(TW'(drs_pkg::VREF_WR_NCK)),
      .step(tick),
      .done(vref_done)
   );

   // ----------------------------------------------------------------
   // refresh debt
   // ----------------------------------------------------------------
   logic do_ref;
   logic signed [4:0] next_debt;

   // debt is frozen in self-refresh, where the dram refreshes itself
   wire in_sr = (state == drs_pkg::DRS_C_SR_ODT) | (state == drs_pkg::DRS_C_SREF);
   wire refi_inc = tick & refi_done & ~in_sr;
   wire debt_full = (ref_debt >= DMAX);
   // R2: never refresh with a bank open
   // R6: pull-in stops once eight are banked
   wire want_ref = banks_idle & (debt_full | ((ref_debt > 5'sh0) & ~ref_defer) | (pull_in & (ref_debt > DMIN)));

   assign refi_ld = (tick & refi_done) | in_sr;
   assign ref_urgent = debt_full;

   // R23: clamp both ways
   always_comb begin
      next_debt = ref_debt;
      if (refi_inc && !do_ref && ref_debt < DMAX) begin
         next_debt = ref_debt + 5'sh1;
      end else if (do_ref && !refi_inc && ref_debt > DMIN) begin
         next_debt = ref_debt - 5'sh1;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ref_debt <= '0;
      end else begin
         ref_debt <= next_debt;
      end
   end

   // ----------------------------------------------------------------
   // command sequencer
   // ----------------------------------------------------------------
   drs_pkg::drs_cstate_t next_state;
   logic [3:0] cmd;
   logic [3:0] next_cmd;
   logic next_cke;
   logic need_ref;
   logic next_need_ref;
   logic slow;
   logic next_slow;
   logic odt_hold;

   // R17: odt held off until tXSDLL has run
   // R9: odt off before and through self-refresh
   wire odt_block = in_sr | (odt_hold & ~dll_done);

   // R15: tXS or tXP before commands, tXSDLL or tXPDLL before dll ones
   assign cmd_ok = (state == drs_pkg::DRS_C_IDLE) & main_done & link.mem_rst_n;
   assign dll_ok = cmd_ok & dll_done;
   assign wr_ok = dll_ok & vref_done;

   always_comb begin
      next_state = state;
      next_cmd = drs_pkg::CMD_DES;
      next_cke = link.cke;
      next_need_ref = need_ref;
      next_slow = slow;
      main_ld = 1'b0;
      main_val = '0;
      dll_ld = 1'b0;
      dll_val = '0;
      vref_ld = 1'b0;
      do_ref = 1'b0;
      if (tick && mem_rst_req) begin
         next_state = drs_pkg::DRS_C_IDLE;
         next_cke = 1'b0;
      end else if (tick) begin
         case (state)
            drs_pkg::DRS_C_IDLE: begin
               next_cke = 1'b1;
               // R16: nothing but deselect until tXS is over
               if (main_done && link.cke) begin
                  if (want_ref) begin
                     // R1: refresh with cke high
                     next_cmd = drs_pkg::CMD_REF;
                     do_ref = 1'b1;
                     next_need_ref = 1'b0;
                     // R4: deselect only for tRFC
                     main_ld = 1'b1;
                     main_val = TW'(drs_pkg::TRFC_NCK);
                     next_state = drs_pkg::DRS_C_REF;
                  // R7: no debt left; R16: one refresh since last exit
                  end else if (sr_req && banks_idle && ref_debt <= 5'sh0 && !need_ref) begin
                     main_ld = 1'b1;
                     main_val = TW'(drs_pkg::ODT_OFF_NCK);
                     next_state = drs_pkg::DRS_C_SR_ODT;
                  // R18: cke falls for power-down only when idle of busy work
                  // R22: no entry on negative debt, so the forced exit comes inside nine tREFI
                  end else if (pd_req && !busy && !debt_full && !ref_debt[4]) begin
                     next_cke = 1'b0;
                     next_slow = banks_idle & ~mr0_a12;
                     main_ld = 1'b1;
                     main_val = TW'(drs_pkg::TCKE_NCK);
                     next_state = drs_pkg::DRS_C_PD;
                  end
               end
            end
            drs_pkg::DRS_C_REF: begin
               if (main_done) begin
                  next_state = drs_pkg::DRS_C_IDLE;
               end
            end
            drs_pkg::DRS_C_SR_ODT: begin
               if (!sr_req || !banks_idle) begin
                  next_state = drs_pkg::DRS_C_IDLE;
               end else if (main_done) begin
                  // R8: refresh code with cke low
                  next_cmd = drs_pkg::CMD_REF;
                  next_cke = 1'b0;
                  // R14: minimum stay of tCKE
                  main_ld = 1'b1;
                  main_val = TW'(drs_pkg::TCKE_NCK);
                  next_state = drs_pkg::DRS_C_SREF;
               end
            end
            drs_pkg::DRS_C_SREF: begin
               // R10: cke stays low until exit
               next_cke = 1'b0;
               if (main_done && !sr_req) begin
                  // R15: exit is cke high with deselect
                  next_cke = 1'b1;
                  next_need_ref = 1'b1;
                  main_ld = 1'b1;
                  main_val = TW'(drs_pkg::TXS_NCK);
                  dll_ld = 1'b1;
                  dll_val = TW'(drs_pkg::TXSDLL_NCK);
                  vref_ld = vref_float;
                  next_state = drs_pkg::DRS_C_IDLE;
               end
            end
            default: begin
               // R20: deselect through tCPDED and the whole stay
               next_cke = 1'b0;
               // R22: tCKE low, forced out before nine tREFI
               if (main_done && (!pd_req || debt_full)) begin
                  next_cke = 1'b1;
                  // R22: tCKE high and R21: tXP after exit
                  main_ld = 1'b1;
                  main_val = TW'(drs_pkg::TPDX_NCK);
                  // R21: slow exit needs tXPDLL
                  dll_ld = slow;
                  dll_val = TW'(drs_pkg::TXPDLL_NCK);
                  next_state = drs_pkg::DRS_C_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state <= drs_pkg::DRS_C_IDLE;
         cmd <= drs_pkg::CMD_DES;
         link.cke <= 1'b0;
         link.odt <= 1'b0;
         link.mem_rst_n <= 1'b0;
         need_ref <= 1'b0;
         slow <= 1'b0;
         odt_hold <= 1'b0;
      end else if (tick) begin
         state <= next_state;
         cmd <= next_cmd;
         link.cke <= next_cke;
         link.odt <= odt_req & ~odt_block;
         link.mem_rst_n <= ~mem_rst_req;
         need_ref <= next_need_ref;
         slow <= next_slow;
         odt_hold <= (state == drs_pkg::DRS_C_SREF && next_state == drs_pkg::DRS_C_IDLE) | (odt_hold & ~dll_done);
      end
   end

   assign link.cs_n = cmd[3];
   assign link.ras_n = cmd[2];
   assign link.cas_n = cmd[1];
   assign link.we_n = cmd[0];

endmodule

// ### src/drs_dram.sv
`timescale 1ns/1ns
module drs_dram #(
   parameter int ROW_W = drs_pkg::ROW_W
) (
   input wire logic resetn,
   drs_link_if.dram link,
   input wire logic bank_open,
   input wire logic dll_locked,
   input wire logic mr1_dll_off,
   input wire logic mr0_a12,
   output logic ref_start,
   output logic [ROW_W-1:0] ref_row,
   output logic banks_closed,
   output logic dll_on,
   output logic dll_rst,
   output logic rx_en,
   output logic term_on,
   output drs_pkg::drs_dstate_t state
);

   generate
      if (ROW_W < 1) begin : g_chk
         $error("drs_dram needs ROW_W of at least 1");
      end
   endgenerate

   // ----------------------------------------------------------------
   // command decode
   // ----------------------------------------------------------------
   logic cke_q;
   logic unlocked_at_pd;
   logic t_load;
   logic [drs_pkg::TW-1:0] t_val;
   logic t_done;

   wire ref_bits = ({link.cs_n, link.ras_n, link.cas_n, link.we_n} == drs_pkg::CMD_REF);
   wire is_nop = link.cs_n | (link.ras_n & link.cas_n & link.we_n);
   // R1: refresh decode
   wire is_ref = cke_q & link.cke & ref_bits;
   // R8: self-refresh entry decode
   wire is_sre = cke_q & ~link.cke & ref_bits;
   // R20: power-down entry decode
   wire is_pde = cke_q & ~link.cke & is_nop;
   wire in_idle = (state == drs_pkg::DRS_D_IDLE);
   wire in_sref = (state == drs_pkg::DRS_D_SREF);
   wire in_pd = (state == drs_pkg::DRS_D_PDP) | (state == drs_pkg::DRS_D_PDA);
   wire sr_tick = in_sref & t_done;
   wire pd_armed = (state == drs_pkg::DRS_D_PDE) & t_done & ~link.cke;
   wire dll_kept = ~mr1_dll_off;

   assign t_load = (in_idle & (is_ref | is_sre | is_pde)) | sr_tick;
   assign t_val = is_ref ? drs_pkg::TW'(drs_pkg::TRFC_NCK - 1) :
                  in_sref ? drs_pkg::TW'(drs_pkg::TREFI_NCK - 1) :
                  is_sre ? drs_pkg::TW'(drs_pkg::TCKE_NCK - 1) :
                  drs_pkg::TW'(drs_pkg::TCPDED_NCK - 1);

   drs_timer #(.W(drs_pkg::TW)) u_timer (
      .clk(link.ck),
      .resetn(resetn),
      .load(t_load),
      .value(t_val),
      .step(1'b1),
      .done(t_done)
   );

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   always_ff @(posedge link.ck or negedge resetn) begin
      if (!resetn) begin
         state <= drs_pkg::DRS_D_RST;
         cke_q <= 1'b0;
         ref_start <= 1'b0;
         ref_row <= '0;
         banks_closed <= 1'b0;
         dll_on <= 1'b0;
         dll_rst <= 1'b0;
         rx_en <= 1'b0;
         term_on <= 1'b0;
         unlocked_at_pd <= 1'b0;
      end else begin
         cke_q <= link.cke;
         ref_start <= 1'b0;
         banks_closed <= 1'b0;
         dll_rst <= 1'b0;
         // R10: odt means nothing while self-refreshing
         term_on <= link.odt & ~in_sref & link.mem_rst_n;
         // R3: row address from the internal counter only
         if (ref_start) begin
            ref_row <= ref_row + 1'b1;
         end
         // R22: reset pin wins from any state, power-down included
         if (!link.mem_rst_n) begin
            state <= drs_pkg::DRS_D_RST;
            rx_en <= 1'b0;
            dll_on <= 1'b0;
         end else begin
            case (state)
               drs_pkg::DRS_D_RST: begin
                  state <= drs_pkg::DRS_D_IDLE;
                  rx_en <= 1'b1;
                  dll_on <= dll_kept;
               end
               drs_pkg::DRS_D_IDLE: begin
                  if (is_ref) begin
                     ref_start <= 1'b1;
                     state <= drs_pkg::DRS_D_REF;
                  end else if (is_sre) begin
                     rx_en <= 1'b0;
                     // R11: dll stops on entry
                     dll_on <= 1'b0;
                     state <= drs_pkg::DRS_D_SREF;
                  end else if (is_pde) begin
                     unlocked_at_pd <= ~dll_locked;
                     state <= drs_pkg::DRS_D_PDE;
                  end
               end
               drs_pkg::DRS_D_REF: begin
                  if (t_done) begin
                     // R3: all banks idle afterwards
                     banks_closed <= 1'b1;
                     state <= drs_pkg::DRS_D_IDLE;
                  end
               end
               drs_pkg::DRS_D_SREF: begin
                  // R13: first refresh within tCKE, then on own timer
                  if (sr_tick) begin
                     ref_start <= 1'b1;
                  end
                  // R10: only cke or the reset pin can end self-refresh
                  if (link.cke) begin
                     rx_en <= 1'b1;
                     // R11: dll back on with a reset
                     dll_on <= dll_kept;
                     dll_rst <= dll_kept;
                     state <= drs_pkg::DRS_D_IDLE;
                  end
               end
               drs_pkg::DRS_D_PDE: begin
                  if (link.cke) begin
                     state <= drs_pkg::DRS_D_IDLE;
                  end else if (pd_armed) begin
                     // R20: receivers off once tCPDED has run
                     rx_en <= 1'b0;
                     // R19: precharge or active power-down
                     state <= bank_open ? drs_pkg::DRS_D_PDA : drs_pkg::DRS_D_PDP;
                     // R21: slow exit turns the dll off
                     if (!bank_open && !mr0_a12) begin
                        dll_on <= 1'b0;
                     end
                  end
               end
               default: begin
                  // R22: exit on cke registered high
                  if (in_pd && link.cke) begin
                     rx_en <= 1'b1;
                     dll_on <= dll_kept;
                     // R21: dll reset flagged when unlocked at entry
                     dll_rst <= unlocked_at_pd & dll_kept;
                     state <= drs_pkg::DRS_D_IDLE;
                  end else if (!in_pd) begin
                     state <= drs_pkg::DRS_D_RST;
                  end
               end
            endcase
         end
      end
   end

endmodule

// ### src/drs_link_if.sv
`timescale 1ns/1ns
interface drs_link_if;
   logic ck;
   logic cke;
   logic cs_n;
   logic ras_n;
   logic cas_n;
   logic we_n;
   logic odt;
   logic mem_rst_n;

   modport ctrl (output ck, output cke, output cs_n, output ras_n, output cas_n, output we_n, output odt,
                 output mem_rst_n);
   modport dram (input ck, input cke, input cs_n, input ras_n, input cas_n, input we_n, input odt,
                 input mem_rst_n);
endinterface

// ### src/drs_pkg.sv
package drs_pkg;

   // ----------------------------------------------------------------
   // clocks
   // ----------------------------------------------------------------
   localparam int CLK_NS = 50;
   // ck toggles every CK_HALF clk cycles
   localparam int CK_HALF = 1;
   localparam int CK_NS = 2 * CK_HALF * CLK_NS;
   localparam int TW = 10;

   // ----------------------------------------------------------------
   // timing, in ns or nCK, and the derived counts in nCK
   // ----------------------------------------------------------------
   localparam int TRFC_NS = 160;
   localparam int TRFC_NCK = (TRFC_NS + CK_NS - 1) / CK_NS;
   // average interval, so it rounds down
   localparam int TREFI_NS = 3900;
   localparam int TREFI_NCK = TREFI_NS / CK_NS;
   localparam int TXS_NS = 170;
   localparam int TXS_NCK = (TXS_NS + CK_NS - 1) / CK_NS;
   localparam int TXSDLL_NCK = 512;
   localparam int TCKE_NS = 300;
   localparam int TCKE_NCK = (TCKE_NS + CK_NS - 1) / CK_NS;
   localparam int TXP_NS = 600;
   localparam int TXP_NCK = (TXP_NS + CK_NS - 1) / CK_NS;
   localparam int TXPDLL_NS = 2400;
   localparam int TXPDLL_NCK = (TXPDLL_NS + CK_NS - 1) / CK_NS;
   localparam int TPDX_NCK = (TXP_NCK > TCKE_NCK) ? TXP_NCK : TCKE_NCK;
   localparam int TCPDED_NCK = 1;
   localparam int ODTL_NCK = 4;
   // ODTL plus half a clock, rounded up to whole clocks
   localparam int ODT_OFF_NCK = ODTL_NCK + 1;
   localparam int VREF_WR_NCK = 512;
   localparam int DEBT_LIMIT = 8;
   localparam int ROW_W = 14;

   // ----------------------------------------------------------------
   // command pins {cs_n, ras_n, cas_n, we_n}
   // ----------------------------------------------------------------
   localparam logic [3:0] CMD_REF = 4'h1;
   localparam logic [3:0] CMD_NOP = 4'h7;
   localparam logic [3:0] CMD_DES = 4'hf;

   // ----------------------------------------------------------------
   // states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      DRS_C_IDLE = 3'h0,
      DRS_C_REF = 3'h1,
      DRS_C_SR_ODT = 3'h2,
      DRS_C_SREF = 3'h3,
      DRS_C_PD = 3'h4
   } drs_cstate_t;

   typedef enum logic [2:0] {
      DRS_D_RST = 3'h0,
      DRS_D_IDLE = 3'h1,
      DRS_D_REF = 3'h2,
      DRS_D_SREF = 3'h3,
      DRS_D_PDE = 3'h4,
      DRS_D_PDP = 3'h5,
      DRS_D_PDA = 3'h6
   } drs_dstate_t;

endpackage

// ### src/drs_timer.sv
`timescale 1ns/1ns
module drs_timer #(
   parameter int W = drs_pkg::TW
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic load,
   input wire logic [W-1:0] value,
   input wire logic step,
   output logic done
);

   generate
      if (W < 2) begin : g_chk
         $error("drs_timer needs W of at least 2");
      end
   endgenerate

   logic [W-1:0] count;

   assign done = (count == '0);

   // load wins over step so a restart is never lost
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         count <= '0;
      end else if (load) begin
         count <= value;
      end else if (step && !done) begin
         count <= count - 1'b1;
      end
   end

endmodule

// ### tb/ddr3_refresh_power_state_control_tb_top.sv
`timescale 1ns/1ns
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin mismatches++; \
   $display("unexpected %s: expected %0h seen %0h", n, e, s); end end
module ddr3_refresh_power_state_control_tb_top;
   // ----------------------------------------------------------------
   // stimulus and wiring
   // ----------------------------------------------------------------
   logic clk = 1'h0, resetn = 1'h1, ref_defer = 1'h0, pull_in = 1'h0, sr_req = 1'h0, pd_req = 1'h0;
   logic busy = 1'h0, banks_idle = 1'h1, mr0_a12 = 1'h1, vref_float = 1'h0, odt_req = 1'h0;
   logic mem_rst_req = 1'h0, bank_open = 1'h0, dll_locked = 1'h1, mr1_dll_off = 1'h0;
   wire ref_urgent, cmd_ok, dll_ok, wr_ok, ref_start, banks_closed, dll_on, rx_en, term_on;
   wire [drs_pkg::ROW_W-1:0] ref_row;
   wire signed [4:0] ref_debt;
   drs_pkg::drs_dstate_t dstate;
   int mismatches = 0;
   int num_checks = 0;
   drs_link_if link ();
   drs_ctrl drs_ctrl_i (.clk, .resetn, .link(link.ctrl), .ref_defer, .pull_in, .sr_req, .pd_req, .busy,
      .banks_idle, .mr0_a12, .vref_float, .odt_req, .mem_rst_req, .ref_urgent, .cmd_ok, .dll_ok,
      .wr_ok, .state(), .ref_debt);
   drs_dram drs_dram_i (.resetn, .link(link.dram), .bank_open, .dll_locked, .mr1_dll_off, .mr0_a12,
      .ref_start, .ref_row, .banks_closed, .dll_on, .dll_rst(), .rx_en, .term_on, .state(dstate));
   drs_assertions drs_assertions_i (.ck(link.ck), .resetn, .cke(link.cke), .cs_n(link.cs_n),
      .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n), .odt(link.odt), .mem_rst_n(link.mem_rst_n));
   initial forever #25 clk = ~clk;
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic wd(input drs_pkg::drs_dstate_t s);
      repeat (1200) if (dstate !== s) @(posedge clk);
      `CHK("dram state", s, dstate)
   endtask
   task automatic wait_cmd_ok();
      repeat (200) if (cmd_ok !== 1'h1) @(posedge clk);
      `CHK("cmd ok", 1'h1, cmd_ok)
   endtask
   task automatic t_ref();
      logic [drs_pkg::ROW_W-1:0] row0;
      repeat (300) if (ref_start !== 1'h1) @(posedge clk);
      row0 = ref_row;
      `CHK("refresh start", 1'h1, ref_start)
      repeat (20) if (banks_closed !== 1'h1) @(posedge clk);
      `CHK("banks closed", 1'h1, banks_closed)
      `CHK("row count", row0 + 1'h1, ref_row)
   endtask
   task automatic t_sr();
      odt_req <= 1'h1;
      vref_float <= 1'h1;
      sr_req <= 1'h1;
      wd(drs_pkg::DRS_D_SREF);
      `CHK("dll on", 1'h0, dll_on)
      `CHK("termination", 1'h0, term_on)
      // the first self refresh must start within twice the minimum stay
      repeat (4 * drs_pkg::TCKE_NCK) if (ref_start !== 1'h1) @(posedge clk);
      `CHK("self refresh start", 1'h1, ref_start)
      sr_req <= 1'h0;
      wait_cmd_ok();
      `CHK("dll ok early", 1'h0, dll_ok)
      `CHK("wr ok early", 1'h0, wr_ok)
      repeat (2400) if (dll_ok !== 1'h1) @(posedge clk);
      `CHK("dll ok late", 1'h1, dll_ok)
      `CHK("wr ok late", 1'h1, wr_ok)
      odt_req <= 1'h0;
   endtask
   task automatic t_debt();
      ref_defer <= 1'h1;
      repeat (1500) if (ref_urgent !== 1'h1) @(posedge clk);
      `CHK("debt high", 5'h08, ref_debt)
      ref_defer <= 1'h0;
      pull_in <= 1'h1;
      repeat (600) if (ref_debt !== 5'h18) @(posedge clk);
      `CHK("debt low", 5'h18, ref_debt)
      pull_in <= 1'h0;
   endtask
   task automatic t_pd();
      busy <= 1'h1;
      pd_req <= 1'h1;
      repeat (20) @(posedge clk);
      `CHK("receivers busy", 1'h1, rx_en)
      busy <= 1'h0;
      bank_open <= 1'h1;
      wd(drs_pkg::DRS_D_PDA);
      repeat (4) @(posedge clk);
      `CHK("receivers off", 1'h0, rx_en)
      pd_req <= 1'h0;
      wait_cmd_ok();
      `CHK("fast exit", 1'h1, dll_ok)
      bank_open <= 1'h0;
      mr0_a12 <= 1'h0;
      pd_req <= 1'h1;
      wd(drs_pkg::DRS_D_PDP);
      `CHK("dll off", 1'h0, dll_on)
      pd_req <= 1'h0;
      wait_cmd_ok();
      `CHK("slow exit", 1'h0, dll_ok)
      pd_req <= 1'h1;
      wd(drs_pkg::DRS_D_PDP);
      mem_rst_req <= 1'h1;
      wd(drs_pkg::DRS_D_RST);
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      // a real falling edge, so every asynchronous reset fires before ck runs
      resetn <= 1'h0;
      repeat (6) @(posedge clk);
      resetn <= 1'h1;
      t_ref();
      t_sr();
      t_debt();
      t_pd();
      print_verdict();
   end
   // a hang is cut well after the slowest scenario could finish
   initial begin
      repeat (30000) @(posedge clk);
      mismatches++;
      print_verdict();
   end
endmodule

// ### tb/drs_assertions.sv
`timescale 1ns/1ns
module drs_assertions (
   input wire logic ck,
   input wire logic resetn,
   input wire logic cke,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic odt,
   input wire logic mem_rst_n
);
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   wire idle_cmd = cs_n | (ras_n & cas_n & we_n);
   wire ref_cmd = ~cs_n & ~ras_n & ~cas_n & we_n;
   logic prev_cke;
   logic in_sr;
   logic ref_seen;
   logic [9:0] xs_cnt;
   logic [9:0] odt_low;
   logic [9:0] pd_cnt;
   wire sre = ref_cmd & prev_cke & ~cke;
   // odt_low and pd_cnt saturate and xs_cnt clears at 0x1ff, so a long quiet stretch cannot wrap them
   always_ff @(posedge ck or negedge resetn) begin
      if (!resetn) begin
         prev_cke <= 1'h0;
         in_sr <= 1'h0;
         ref_seen <= 1'h1;
         xs_cnt <= 10'h000;
         odt_low <= 10'h000;
         pd_cnt <= 10'h000;
      end else begin
         prev_cke <= cke;
         in_sr <= sre | (in_sr & ~cke);
         ref_seen <= (ref_seen | (ref_cmd & cke)) & ~sre;
         if (in_sr & cke) begin
            xs_cnt <= 10'h001;
         end else if (xs_cnt != 10'h000 && xs_cnt != 10'h1ff && cke) begin
            xs_cnt <= xs_cnt + 10'h001;
         end else begin
            xs_cnt <= 10'h000;
         end
         odt_low <= odt ? 10'h000 : odt_low + {9'h000, odt_low != 10'h3ff};
         pd_cnt <= (~cke & ~in_sr & mem_rst_n) ? pd_cnt + {9'h000, pd_cnt != 10'h3ff} : 10'h000;
      end
   end
   // ----------------------------------------------------------------
   // link checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge ck);
   endclocking
   default disable iff (!resetn);
   a_ref_quiet_time: assert property (ref_cmd & cke |=> idle_cmd)
      else $error("command inside refresh cycle");
   a_sre_odt_low: assert property (sre |-> odt_low >= drs_pkg::ODT_OFF_NCK)
      else $error("termination not off before self-refresh");
   a_cke_low_min: assert property ($fell(cke) && mem_rst_n |=> !cke [*2])
      else $error("cke low too short");
   a_cke_high_min: assert property ($rose(cke) |=> cke [*2])
      else $error("cke high too short");
   a_exit_quiet_txs: assert property ($rose(cke) && $past(mem_rst_n) |-> idle_cmd [*2])
      else $error("command too soon after exit");
   a_pd_entry_quiet: assert property ($fell(cke) && !ref_cmd |-> idle_cmd ##1 idle_cmd)
      else $error("command around power-down entry");
   a_odt_off_xsdll: assert property (xs_cnt != 10'h000 && cke |-> !odt)
      else $error("termination on during dll relock");
   a_reentry_needs_ref: assert property (sre |-> ref_seen)
      else $error("self-refresh re-entry without refresh");
   a_pd_bounded: assert property (pd_cnt <= 9 * drs_pkg::TREFI_NCK)
      else $error("power-down too long");
   c_self_refresh: cover property (sre);
   c_power_down: cover property ($fell(cke) && !ref_cmd && mem_rst_n);
   c_refresh: cover property (ref_cmd & cke);
endmodule
